// file: rtl/irs_slave.sv
// Register slave end of the two-wire host port.
// Assumes the host drives the clock line; register storage lives outside.
`timescale 1ns/1ns
module irs_slave
    import irs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    irs_link_if.dev link,
    // Address configuration
    input wire logic [1:0] addr_pins,
    input wire logic [1:0] addr_nv,
    input wire logic addr_from_nv,
    input wire logic point_to_point_fast_variant,
    // Register side
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we,
    output logic reg_re,
    input wire logic [7:0] reg_rdata,
    output logic busy
);

    // ------------------------------------------------------------------
    // Input synchronisers and spike filters
    // ------------------------------------------------------------------
    logic [1:0] scl_sync_ff, sda_sync_ff;
    logic [FILT_LEN-1:0] scl_hist_ff, sda_hist_ff;
    logic scl_ff, sda_ff, scl_q_ff, sda_q_ff;
    logic [1:0] pins_s1_ff, pins_s2_ff;

    // Address straps are pins too, so they pass two flops before decoding
    always_ff @(posedge clk) begin
        scl_sync_ff <= {scl_sync_ff[0], link.scl};
        sda_sync_ff <= {sda_sync_ff[0], link.sda};
        pins_s1_ff <= addr_pins;
        pins_s2_ff <= pins_s1_ff;
    end

    // Filtered level moves only after FILT_LEN agreeing samples
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_hist_ff <= '1;
            sda_hist_ff <= '1;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_hist_ff <= {scl_hist_ff[FILT_LEN-2:0], scl_sync_ff[1]};
            sda_hist_ff <= {sda_hist_ff[FILT_LEN-2:0], sda_sync_ff[1]};
            if (&scl_hist_ff || ~|scl_hist_ff) scl_ff <= scl_hist_ff[0];
            if (&sda_hist_ff || ~|sda_hist_ff) sda_ff <= sda_hist_ff[0];
            scl_q_ff <= scl_ff;
            sda_q_ff <= sda_ff;
        end
    end

    wire scl_rise = scl_ff & ~scl_q_ff;
    wire scl_fall = ~scl_ff & scl_q_ff;
    wire start_det = scl_ff & scl_q_ff & sda_q_ff & ~sda_ff;
    wire stop_det = scl_ff & scl_q_ff & ~sda_q_ff & sda_ff;

    // ------------------------------------------------------------------
    // Address match
    // ------------------------------------------------------------------
    // Pin straps in the point-to-point variant only carry the low bit
    wire [1:0] pin_bits = point_to_point_fast_variant ? {1'b0, pins_s2_ff[0]} : pins_s2_ff;
    wire [1:0] low_bits = addr_from_nv ? addr_nv : pin_bits;
    wire [6:0] own_addr = {ADDR_HI, low_bits};

    // ------------------------------------------------------------------
    // Byte engine
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TX_ACK = 3'b100
    } irs_state_type;

    irs_state_type state_ff;
    logic [2:0] bit_ff;
    logic [7:0] sh_ff;
    logic [1:0] byte_ff;  // 0 address, 1 register byte, 2 data
    logic rd_ff, ack_ff, drv_ff, drv_val_ff;
    logic [6:0] ptr_ff;
    logic [7:0] wdata_ff;
    logic we_ff, re_ff, bus_busy_ff;

    wire [7:0] rx_byte = {sh_ff[6:0], sda_ff};
    // General call 0 never equals own address since upper bits are fixed
    wire addr_hit = (rx_byte[7:1] == own_addr);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            bit_ff <= 3'h0;
            sh_ff <= 8'h00;
            byte_ff <= 2'h0;
            rd_ff <= 1'b0;
            ack_ff <= 1'b0;
            drv_ff <= 1'b0;
            drv_val_ff <= 1'b1;
            ptr_ff <= PTR_RST;
            wdata_ff <= 8'h00;
            we_ff <= 1'b0;
            re_ff <= 1'b0;
            bus_busy_ff <= 1'b0;
        end else begin
            we_ff <= 1'b0;
            re_ff <= 1'b0;
            if (start_det) begin
                // Repeated start restarts framing without leaving busy
                state_ff <= ST_RX;
                bus_busy_ff <= 1'b1;
                bit_ff <= 3'h0;
                byte_ff <= 2'h0;
                drv_ff <= 1'b0;
            end else if (stop_det) begin
                state_ff <= ST_IDLE;
                bus_busy_ff <= 1'b0;
                drv_ff <= 1'b0;
            end else begin
                case (state_ff)
                    ST_IDLE: drv_ff <= 1'b0;
                    ST_RX: begin
                        if (scl_rise) begin
                            sh_ff <= rx_byte;
                            bit_ff <= 3'(bit_ff + 3'h1);
                        end
                        if (scl_rise && bit_ff == 3'h7) begin
                            state_ff <= ST_RX_ACK;
                            if (byte_ff == 2'h0) begin
                                ack_ff <= addr_hit;
                                rd_ff <= rx_byte[0];
                            end else begin
                                ack_ff <= 1'b1;
                                if (byte_ff == 2'h1) begin
                                    ptr_ff <= rx_byte[6:0];
                                end else begin
                                    wdata_ff <= rx_byte;
                                    we_ff <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_RX_ACK: begin
                        // Drive ack low after the eighth falling edge, release after ninth
                        if (scl_fall && !drv_ff) begin
                            if (!ack_ff) begin
                                state_ff <= ST_IDLE;
                            end else begin
                                drv_ff <= 1'b1;
                                drv_val_ff <= 1'b0;
                            end
                        end else if (scl_fall && drv_ff) begin
                            drv_ff <= 1'b0;
                            bit_ff <= 3'h0;
                            if (byte_ff == 2'h2) ptr_ff <= irs_next_ptr(ptr_ff);
                            if (byte_ff == 2'h0 && rd_ff) begin
                                state_ff <= ST_TX;
                                sh_ff <= reg_rdata;
                                re_ff <= 1'b1;
                                drv_ff <= 1'b1;
                                drv_val_ff <= reg_rdata[7];
                            end else begin
                                state_ff <= ST_RX;
                                byte_ff <= (byte_ff == 2'h0) ? 2'h1 : 2'h2;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_ff <= 3'(bit_ff + 3'h1);
                        end
                        if (scl_fall) begin
                            if (bit_ff == 3'h0) begin
                                // Eight bits sent: release for master ack
                                drv_ff <= 1'b0;
                                state_ff <= ST_TX_ACK;
                                ptr_ff <= irs_next_ptr(ptr_ff);
                            end else begin
                                sh_ff <= {sh_ff[6:0], 1'b0};
                                drv_val_ff <= sh_ff[6];
                            end
                        end
                    end
                    ST_TX_ACK: begin
                        if (scl_rise) begin
                            ack_ff <= ~sda_ff;
                        end
                        if (scl_fall) begin
                            if (!ack_ff) begin
                                state_ff <= ST_IDLE;
                            end else begin
                                state_ff <= ST_TX;
                                bit_ff <= 3'h0;
                                sh_ff <= reg_rdata;
                                re_ff <= 1'b1;
                                drv_ff <= 1'b1;
                                drv_val_ff <= reg_rdata[7];
                            end
                        end
                    end
                    default: state_ff <= ST_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Device drives data only; clock is never touched, so no stretching
    assign link.sda_s_o = drv_val_ff;
    assign link.sda_s_oe = drv_ff & ~drv_val_ff;
    assign reg_addr = ptr_ff;
    assign reg_wdata = wdata_ff;
    assign reg_we = we_ff;
    assign reg_re = re_ff;
    // Busy follows the bus, not the engine, which may go quiet before the stop
    assign busy = bus_busy_ff;

endmodule : irs_slave

// file: rtl/irs_pkg.sv
// Constants shared by the two-wire register slave port and its host end.
// Assumes both ends run on one 100 MHz clock with a synchronous active-low reset.
package irs_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int FAST_BPS = 400_000;
    localparam int FASTPLUS_BPS = 1_000_000;
    localparam int P2P_BAUD = 5_000_000;
    // Quarter bit period of the host clock in system cycles, rounded up
    localparam int QTR_FAST = (CLK_HZ + 4 * FAST_BPS - 1) / (4 * FAST_BPS);
    localparam int QTR_FASTPLUS = (CLK_HZ + 4 * FASTPLUS_BPS - 1) / (4 * FASTPLUS_BPS);
    localparam int QTR_P2P = (CLK_HZ + 4 * P2P_BAUD - 1) / (4 * P2P_BAUD);
    localparam int FILT_LEN = 3;

    // ------------------------------------------------------------------
    // Addressing
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_HI = 5'h0a;
    localparam logic [6:0] FIFO_REG = 7'h05;  // Arbitrary FIFO register index
    localparam logic [6:0] PTR_RST = 7'h00;

    // Speed selection for the host end
    typedef enum logic [1:0] {
        IRS_SPD_FAST = 2'b00,
        IRS_SPD_FASTPLUS = 2'b01,
        IRS_SPD_P2P = 2'b10
    } irs_speed_type;

    // Next pointer: FIFO address stays, others step by one
    function automatic logic [6:0] irs_next_ptr(input logic [6:0] p);
        irs_next_ptr = (p == FIFO_REG) ? p : 7'(p + 7'h01);
    endfunction : irs_next_ptr

endpackage : irs_pkg

// file: rtl/irs_link_if.sv
// Two-wire link between host end and register slave end.
// Assumes open-drain behaviour; a released line reads high.
`timescale 1ns/1ns
interface irs_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // Wired-AND resolution of the shared lines
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

    modport host (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
        input scl, input sda);
    modport dev (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : irs_link_if

// file: rtl/irs_host.sv
// Host (bus master) end of the two-wire register port.
// Assumes one transfer request at a time; the slave never stretches the clock.
`timescale 1ns/1ns
module irs_host
    import irs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link
    irs_link_if.host link,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [6:0] req_dev,
    input wire logic req_rd,
    input wire logic [7:0] req_data,
    input wire logic req_last,
    input wire logic [1:0] speed,
    // Answer
    output logic [7:0] rsp_data,
    output logic rsp_valid,
    output logic rsp_nack
);

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_START = 3'b001,
        HS_BIT = 3'b010,
        HS_STOP = 3'b011,
        HS_NEXT = 3'b100
    } irs_hstate_type;

    irs_hstate_type st_ff;
    logic [7:0] div_ff;
    logic [1:0] ph_ff;
    logic [3:0] bit_ff;
    logic [8:0] sh_ff;
    logic rd_ff, last_ff, first_ff, scl_ff, sda_ff, ack_ff;
    logic [7:0] rsp_ff;
    logic rsp_v_ff, nack_ff;
    logic [1:0] sda_sync_ff;

    // Quarter-period tick; speeds above the limits are not offered
    wire [7:0] qtr = (speed == IRS_SPD_P2P) ? 8'(QTR_P2P) :
        (speed == IRS_SPD_FASTPLUS) ? 8'(QTR_FASTPLUS) : 8'(QTR_FAST);
    wire tick = (div_ff == 8'(qtr - 8'h01));

    always_ff @(posedge clk) sda_sync_ff <= {sda_sync_ff[0], link.sda};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= HS_IDLE;
            div_ff <= 8'h00;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            sh_ff <= 9'h1ff;
            rd_ff <= 1'b0;
            last_ff <= 1'b0;
            first_ff <= 1'b1;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            ack_ff <= 1'b0;
            rsp_ff <= 8'h00;
            rsp_v_ff <= 1'b0;
            nack_ff <= 1'b0;
        end else begin
            rsp_v_ff <= 1'b0;
            div_ff <= tick ? 8'h00 : 8'(div_ff + 8'h01);
            case (st_ff)
                HS_IDLE: if (req_valid) begin
                    // First byte of a frame is the address; later ones data
                    sh_ff <= first_ff ? {req_dev, req_rd, 1'b1} :
                        {req_data, req_last | ~req_rd};
                    rd_ff <= first_ff ? 1'b0 : req_rd;
                    last_ff <= req_last;
                    st_ff <= first_ff ? HS_START : HS_BIT;
                    ph_ff <= 2'h0;
                    bit_ff <= 4'h0;
                end
                HS_START: if (tick) begin
                    ph_ff <= 2'(ph_ff + 2'h1);
                    if (ph_ff == 2'h0) begin
                        sda_ff <= 1'b1;
                    end else if (ph_ff == 2'h1) begin
                        scl_ff <= 1'b1;
                    end else if (ph_ff == 2'h2) begin
                        sda_ff <= 1'b0;
                    end else begin
                        scl_ff <= 1'b0;
                        st_ff <= HS_BIT;
                    end
                end
                HS_BIT: if (tick) begin
                    ph_ff <= 2'(ph_ff + 2'h1);
                    case (ph_ff)
                        2'h0: sda_ff <= rd_ff && bit_ff != 4'h8 ? 1'b1 : sh_ff[8];
                        2'h1: scl_ff <= 1'b1;
                        2'h2: begin
                            sh_ff <= {sh_ff[7:0], sda_sync_ff[1]};
                            if (bit_ff == 4'h8) ack_ff <= ~sda_sync_ff[1];
                        end
                        default: begin
                            scl_ff <= 1'b0;
                            bit_ff <= 4'(bit_ff + 4'h1);
                            if (bit_ff == 4'h8) st_ff <= HS_NEXT;
                        end
                    endcase
                end
                HS_NEXT: begin
                    rsp_ff <= sh_ff[8:1];
                    rsp_v_ff <= 1'b1;
                    nack_ff <= ~ack_ff & ~rd_ff;
                    first_ff <= last_ff | (~ack_ff & ~rd_ff);
                    st_ff <= (last_ff | (~ack_ff & ~rd_ff)) ? HS_STOP : HS_IDLE;
                    ph_ff <= 2'h0;
                end
                HS_STOP: if (tick) begin
                    ph_ff <= 2'(ph_ff + 2'h1);
                    if (ph_ff == 2'h0) begin
                        sda_ff <= 1'b0;
                    end else if (ph_ff == 2'h1) begin
                        scl_ff <= 1'b1;
                    end else if (ph_ff == 2'h2) begin
                        sda_ff <= 1'b1;
                        st_ff <= HS_IDLE;
                    end
                end
                default: st_ff <= HS_IDLE;
            endcase
        end
    end

    // Read bytes: master acks unless last, leaving ack high ends the read
    // The ack bit value for reads is carried in sh_ff[8] by req_last
    assign req_ready = (st_ff == HS_IDLE);
    assign link.scl_o = scl_ff;
    assign link.scl_oe = ~scl_ff;
    assign link.sda_m_o = sda_ff;
    assign link.sda_m_oe = ~sda_ff;
    assign rsp_data = rsp_ff;
    assign rsp_valid = rsp_v_ff;
    assign rsp_nack = nack_ff;

endmodule : irs_host

// file: tb/irs_link_assertions.sv
// Checker for the two-wire link between the host end and the register slave end.
// Assumes it sees every enable of both ends and the resolved lines.
`timescale 1ns/1ns
module irs_link_assertions
    import irs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link drivers and resolved lines
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    // ------------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------------
    logic scl_q_ff;
    logic sda_q_ff;
    logic first_ff;
    logic rd_ff;
    logic [3:0] bit_ff;
    logic [7:0] sh_ff;
    // Raw lines are fine here: the host makes clean edges, only the slave needs a filter
    wire logic start = scl && scl_q_ff && sda_q_ff && !sda;
    wire logic rise = scl && !scl_q_ff;
    wire logic ack_rise = rise && (bit_ff == 4'h8);
    wire logic [3:0] nxt_bit = (start || ack_rise) ? 4'h0 : rise ? 4'(bit_ff + 4'h1) : bit_ff;
    wire logic nxt_first = start || (first_ff && !ack_rise);
    wire logic nxt_rd = (rise && first_ff && bit_ff == 4'h7) ? sda : rd_ff;
    wire logic [7:0] nxt_sh = rise ? {sh_ff[6:0], sda} : sh_ff;

    // Line history, bit count and first-byte state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {scl_q_ff, sda_q_ff, first_ff, rd_ff, bit_ff, sh_ff} <= {1'b1, 1'b1, 14'h0};
        end else begin
            {scl_q_ff, sda_q_ff, first_ff, rd_ff, bit_ff, sh_ff} <=
                {scl, sda, nxt_first, nxt_rd, nxt_bit, nxt_sh};
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_low_soon;
        ##[1:300] !scl;
    endsequence
    sequence s_low_run;
        (!scl) [*8];
    endsequence

    a_slave_open_drain: assert property (sda_s_oe |-> !sda_s_o)
        else $error("slave drives data line high");
    a_host_open_drain: assert property ((scl_oe |-> !scl_o) and (sda_m_oe |-> !sda_m_o))
        else $error("host drives a line high");
    a_slave_moves_low: assert property ($changed(sda_s_oe) |-> !scl && !$past(scl))
        else $error("slave data moved while clock high");
    a_cond_by_host: assert property (scl && $past(scl) && $changed(sda) |->
        !sda_s_oe && !$past(sda_s_oe))
        else $error("slave made a start or stop");
    a_drive_held: assert property (scl && $past(scl) && $past(sda_s_oe) |-> sda_s_oe)
        else $error("slave let go during clock high");
    a_high_ends: assert property ($rose(scl) && sda_s_oe |-> s_low_soon)
        else $error("clock high too long while slave drives");
    a_low_min: assert property ($fell(scl) |-> s_low_run)
        else $error("clock low period too short");
    a_write_bits_free: assert property (rise && bit_ff < 4'h8 && (first_ff || !rd_ff)
        |-> !sda_s_oe)
        else $error("slave drove a host data bit");
    a_read_ack_free: assert property (ack_rise && !first_ff && rd_ff |-> !sda_s_oe)
        else $error("slave drove the read acknowledge");
    a_foreign_silent: assert property (ack_rise && first_ff && sh_ff[7:3] != ADDR_HI
        |-> !sda_s_oe)
        else $error("slave acked a foreign address");
    a_data_acked: assert property (ack_rise && !first_ff && !rd_ff |-> sda_s_oe && !sda)
        else $error("slave did not ack a written byte");
endmodule : irs_link_assertions

// file: tb/tb_i2c_register_slave_port.sv
// Testbench joining host end and register slave end over the link.
// Assumes a 100 MHz clock; a small register model answers the slave.
`timescale 1ns/1ns
module tb_i2c_register_slave_port;
    import irs_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam logic [6:0] DEV = {ADDR_HI, 2'b11};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_rd = 1'b0;
    logic req_last = 1'b0;
    logic [6:0] req_dev = 7'h00;
    logic [7:0] req_data = 8'h00;
    logic [1:0] speed = IRS_SPD_FAST;
    logic [1:0] addr_pins = 2'b11;
    logic [1:0] addr_nv = 2'b00;
    logic addr_from_nv = 1'b0;
    logic p2p_sel = 1'b0;
    logic req_ready, rsp_valid, rsp_nack, reg_we, reg_re, busy;
    logic [7:0] rsp_data, reg_wdata, got;
    logic [6:0] reg_addr;
    logic [7:0] fifo_cnt_ff = 8'h30;
    logic [6:0] wa[$];
    logic [7:0] wd[$];
    int n_errors = 0;
    int n_compared = 0;

    always #5 clk = ~clk;
    // Register model: FIFO place returns a running count, others a pattern of the address
    wire logic [7:0] reg_rdata = (reg_addr == FIFO_REG) ? fifo_cnt_ff : {1'b0, reg_addr} ^ 8'ha5;
    always @(posedge clk) begin
        if (reg_re && reg_addr == FIFO_REG) begin
            fifo_cnt_ff <= fifo_cnt_ff + 8'h01;
        end
        if (reg_we) begin
            wa.push_back(reg_addr);
            wd.push_back(reg_wdata);
        end
    end

    irs_link_if irs_link_if_inst ();
    irs_slave irs_slave_inst (.clk(clk), .rst_n(rst_n), .link(irs_link_if_inst),
        .addr_pins(addr_pins), .addr_nv(addr_nv), .addr_from_nv(addr_from_nv),
        .point_to_point_fast_variant(p2p_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .busy(busy));
    irs_host irs_host_inst (.clk(clk), .rst_n(rst_n), .link(irs_link_if_inst),
        .req_valid(req_valid), .req_ready(req_ready), .req_dev(req_dev), .req_rd(req_rd),
        .req_data(req_data), .req_last(req_last), .speed(speed), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .rsp_nack(rsp_nack));
    irs_link_assertions irs_link_assertions_inst (.clk(clk), .rst_n(rst_n),
        .scl_o(irs_link_if_inst.scl_o), .scl_oe(irs_link_if_inst.scl_oe),
        .sda_m_o(irs_link_if_inst.sda_m_o), .sda_m_oe(irs_link_if_inst.sda_m_oe),
        .sda_s_o(irs_link_if_inst.sda_s_o), .sda_s_oe(irs_link_if_inst.sda_s_oe),
        .scl(irs_link_if_inst.scl), .sda(irs_link_if_inst.sda));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check8

    // One byte request; exp_nack of x means the ack is not judged
    task automatic xfer(input logic [6:0] dev, input logic rd, input logic [7:0] d,
        input logic last, input logic exp_nack);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 9000) begin
            @(posedge clk);
            #1;
            n++;
        end
        {req_valid, req_dev, req_rd, req_data, req_last} = {1'b1, dev, rd, d, last};
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (rsp_valid !== 1'b1 && n < 9000);
        got = rsp_data;
        check8("answer", 8'h01, {7'h00, rsp_valid});
        if (exp_nack !== 1'bx) begin
            check8("nack", {7'h00, exp_nack}, {7'h00, rsp_nack});
        end
    endtask : xfer

    task automatic wr_frame(input logic [7:0] ptr, input int n, input logic [7:0] d0);
        wa.delete();
        wd.delete();
        xfer(DEV, 1'b0, 8'h00, 1'b0, 1'b0);
        xfer(DEV, 1'b0, ptr, n == 0, 1'b0);
        for (int i = 0; i < n; i++) begin
            xfer(DEV, 1'b0, 8'(d0 + i), i == n - 1, 1'b0);
        end
    endtask : wr_frame

    task automatic check_writes(input logic [6:0] ptr, input logic step, input logic [7:0] d0);
        check8("write count", 8'h03, 8'(wa.size()));
        for (int i = 0; i < 3 && i < wa.size(); i++) begin
            check8("write addr", {1'b0, 7'(ptr + (step ? i : 0))}, {1'b0, wa[i]});
            check8("write data", 8'(d0 + i), wd[i]);
        end
    endtask : check_writes

    task automatic one_addr(input logic nv_sel, input logic [1:0] nv, input logic [1:0] pins,
        input logic p2p, input logic [1:0] spd, input logic [6:0] dev, input logic exp_nack);
        {addr_from_nv, addr_nv, addr_pins, p2p_sel, speed} = {nv_sel, nv, pins, p2p, spd};
        xfer(dev, 1'b0, 8'h00, 1'b0, exp_nack);
        if (!exp_nack) begin
            xfer(dev, 1'b0, 8'h20, 1'b1, 1'b0);
        end
    endtask : one_addr

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Writes across the top of the pointer range, where it wraps
    task automatic t_write_inc();
        speed = IRS_SPD_FAST;
        wr_frame(8'h7e, 3, 8'hc1);
        check_writes(7'h7e, 1'b1, 8'hc1);
    endtask : t_write_inc

    task automatic t_fifo_write();
        speed = IRS_SPD_FASTPLUS;
        wr_frame({1'b0, FIFO_REG}, 3, 8'h40);
        check_writes(FIFO_REG, 1'b0, 8'h40);
    endtask : t_fifo_write

    // Read from the last place: pointer wraps, last byte not acked by the host
    task automatic t_read_inc();
        wr_frame(8'h7f, 0, 8'h00);
        xfer(DEV, 1'b1, 8'h00, 1'b0, 1'b0);
        check8("busy", 8'h01, {7'h00, busy});
        for (int i = 0; i < 3; i++) begin
            xfer(DEV, 1'b1, 8'h00, i == 2, 1'bx);
            check8("read data", {1'b0, 7'(7'h7f + i)} ^ 8'ha5, got);
        end
        for (int n = 0; n < 3000 && busy !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        check8("idle", 8'h00, {7'h00, busy});
    endtask : t_read_inc

    task automatic t_fifo_read();
        logic [7:0] base;
        wr_frame({1'b0, FIFO_REG}, 0, 8'h00);
        base = fifo_cnt_ff;
        xfer(DEV, 1'b1, 8'h00, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            xfer(DEV, 1'b1, 8'h00, i == 2, 1'bx);
            check8("fifo data", 8'(base + i), got);
        end
    endtask : t_fifo_read

    // Address matching by pins, stored setting and the point-to-point variant
    task automatic t_addr();
        one_addr(1'b0, 2'b00, 2'b10, 1'b0, IRS_SPD_FASTPLUS, {ADDR_HI, 2'b10}, 1'b0);
        one_addr(1'b0, 2'b00, 2'b10, 1'b0, IRS_SPD_FASTPLUS, {ADDR_HI, 2'b01}, 1'b1);
        one_addr(1'b0, 2'b00, 2'b10, 1'b0, IRS_SPD_FASTPLUS, 7'h00, 1'b1);
        one_addr(1'b1, 2'b01, 2'b10, 1'b0, IRS_SPD_FASTPLUS, {ADDR_HI, 2'b01}, 1'b0);
        one_addr(1'b1, 2'b01, 2'b10, 1'b0, IRS_SPD_FASTPLUS, {ADDR_HI, 2'b10}, 1'b1);
        one_addr(1'b0, 2'b00, 2'b11, 1'b1, IRS_SPD_P2P, {ADDR_HI, 2'b01}, 1'b0);
        one_addr(1'b0, 2'b00, 2'b11, 1'b1, IRS_SPD_P2P, {ADDR_HI, 2'b11}, 1'b1);
        one_addr(1'b0, 2'b00, 2'b11, 1'b0, IRS_SPD_FASTPLUS, DEV, 1'b0);
    endtask : t_addr

    task automatic results();
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // Watchdog: the run needs about 40k cycles
    initial begin
        #1_000_000;
        n_errors++;
        $display("mismatch watchdog expected finish seen timeout");
        results();
    end

    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        t_write_inc();
        t_fifo_write();
        t_read_inc();
        t_fifo_read();
        t_addr();
        results();
    end
endmodule : tb_i2c_register_slave_port
